/* File: src/wdt_pkg.sv */
// constants shared by the watchdog timer unit
// assumes a single 50 MHz system clock and a plain register port
package wdt_pkg;
   // ********************************
   // register map (word indices)
   // ********************************
   localparam int ADDR_W = 3;
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_OPTION = 3'h1;
   localparam logic [2:0] REG_CONFIG = 3'h2;
   localparam logic [2:0] REG_STATUS = 3'h3;
   localparam logic [2:0] REG_MASK = 3'h4;
   // ********************************
   // field positions
   // ********************************
   localparam int CTRL_SWEN_BIT = 0;
   localparam int CTRL_PS_LSB = 1;
   localparam int CTRL_PS_MSB = 4;
   localparam int OPT_PSA_BIT = 3;
   localparam int OPT_RATE_MSB = 2;
   localparam int CFG_FUSE_BIT = 3;
   localparam int ST_TIMEOUT_BIT = 0;
   localparam int ST_OSCFAIL_BIT = 1;
   localparam int STATUS_W = 2;
   // ********************************
   // reset values and period codes
   // ********************************
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [3:0] PERIOD_RESET = 4'h4;
   localparam logic [3:0] PERIOD_MAX = 4'hB;
   localparam int PRESC_BASE_LOG2 = 5;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   // ********************************
   // power state of the core
   // ********************************
   typedef enum logic [1:0] {
      PS_RUN = 2'b01,
      PS_SLEEP = 2'b10
   } power_state_t;
endpackage : wdt_pkg

/* File: src/watchdog_timer_unit.sv */
// watchdog timer unit: prescalers, enable logic, clear sources, registers
// assumes core control strobes are on sys_clk_in and the slow oscillator
// arrives as a free-running level from outside this clock domain
//
// Functional notes
// - The counter advances only on ticks of the 31 kHz slow oscillator.
// - A 16-bit prescaler divides the slow oscillator by 32 up to 65536.
// - Period select codes 0000 to 1011 pick powers of two from 1:32 to 1:65536.
// - Every reset returns the period select field to code 0100, a 1:512 division.
// - The watchdog is held cleared while the start-up timer counts.
// - A set fuse enable bit keeps the watchdog running regardless of software.
// - With the fuse clear, the software enable bit turns the watchdog on and off.
// - The software enable bit is control bit 0 and resets to 0.
// - Clear instruction, oscillator failure and a disabled watchdog clear the counters.
// - After a crystal-mode sleep exit the watchdog stays cleared until start-up ends.
// - The option register can route the shared 8-bit prescaler into the watchdog path.
// - The slow oscillator stable flag does not follow watchdog use of it.
// - Entering sleep clears the counter but leaves it running.
// - Any wake from sleep clears the watchdog.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module watchdog_timer_unit
   import wdt_pkg::*;
#(
   parameter int PRESC_W = 16,
   parameter int POST_W = 8,
   parameter logic [7:0] CONFIG_RESET = 8'h00
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // register port
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // oscillator and core events
   input wire logic slow_osc_in,
   input wire logic slow_osc_ready_in,
   input wire logic clear_wdt_in,
   input wire logic osc_fail_in,
   input wire logic ost_busy_in,
   input wire logic ost_done_in,
   input wire logic xtal_mode_in,
   input wire logic sleep_enter_in,
   input wire logic sleep_exit_in,
   // results
   output logic timeout_reset_out,
   output logic timeout_wake_out,
   output logic wdt_running_out,
   output logic slow_osc_stable_out,
   output logic irq_out
);
   // ********************************
   // registers and state
   // ********************************
   logic swen_q;
   logic [3:0] period_q;
   logic [7:0] option_q;
   logic [7:0] config_q;
   logic [STATUS_W-1:0] status_q;
   logic [STATUS_W-1:0] mask_q;
   logic [PRESC_W-1:0] presc_q;
   logic [POST_W-1:0] post_q;
   logic osc_s1_q;
   logic osc_s2_q;
   logic osc_s3_q;
   logic hold_q;
   power_state_t pstate_q;
   logic slow_tick;
   logic wdt_on;
   logic clr;
   logic div_evt;
   logic timeout_evt;
   logic [PRESC_W-1:0] presc_term;
   logic [POST_W-1:0] post_term;
   logic [3:0] wr_period;
   logic wr_ctrl;

   // ********************************
   // slow oscillator tick
   // ********************************
   // two-stage synchroniser; the edge is taken between stages two and three
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end else begin
         osc_s1_q <= slow_osc_in;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end
   assign slow_tick = osc_s2_q & ~osc_s3_q;

   // ********************************
   // enable and clear sources
   // ********************************
   // fuse overrides software
   assign wdt_on = config_q[CFG_FUSE_BIT] | swen_q;
   assign clr = ~wdt_on | clear_wdt_in | osc_fail_in | sleep_enter_in | sleep_exit_in
              | ost_busy_in | hold_q;

   // crystal-mode wake holds the count until the start-up timer is done
   // hold after sleep exit
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         hold_q <= 1'b0;
      end else if (sleep_exit_in && xtal_mode_in) begin
         hold_q <= 1'b1;
      end else if (ost_done_in) begin
         hold_q <= 1'b0;
      end
   end

   // power state decides what a timeout means
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         pstate_q <= PS_RUN;
      end else begin
         case (pstate_q)
            PS_RUN: begin
               if (sleep_enter_in) begin
                  pstate_q <= PS_SLEEP;
               end
            end
            PS_SLEEP: begin
               if (sleep_exit_in) begin
                  pstate_q <= PS_RUN;
               end
            end
            default: begin
               pstate_q <= PS_RUN;
            end
         endcase
      end
   end

   // ********************************
   // prescalers
   // ********************************
   // terminal counts from the period code and the option rate bits
   assign presc_term = PRESC_W'(((PRESC_W+1)'(1) << (PRESC_BASE_LOG2 + int'(period_q))) - 1);
   assign post_term = POST_W'(((POST_W+1)'(1) << int'(option_q[OPT_RATE_MSB:0])) - 1);
   assign div_evt = slow_tick & ~clr & (presc_q == presc_term);
   // shared prescaler in the path when assigned
   assign timeout_evt = div_evt & (~option_q[OPT_PSA_BIT] | (post_q == post_term));

   always_ff @(posedge sys_clk_in) begin
      if (reset_in || clr) begin
         presc_q <= '0;
      end else if (slow_tick) begin
         presc_q <= div_evt ? '0 : presc_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in || clr || !option_q[OPT_PSA_BIT]) begin
         post_q <= '0;
      end else if (div_evt) begin
         post_q <= (post_q == post_term) ? '0 : post_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         timeout_reset_out <= 1'b0;
         timeout_wake_out <= 1'b0;
      end else begin
         timeout_reset_out <= timeout_evt & (pstate_q == PS_RUN);
         timeout_wake_out <= timeout_evt & (pstate_q == PS_SLEEP);
      end
   end

   // ********************************
   // control registers
   // ********************************
   assign wr_ctrl = wr_in && (addr_in == REG_CTRL);
   assign wr_period = (wdata_in[CTRL_PS_MSB:CTRL_PS_LSB] > PERIOD_MAX) ? PERIOD_MAX
                    : wdata_in[CTRL_PS_MSB:CTRL_PS_LSB];

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         period_q <= CTRL_RESET[CTRL_PS_MSB:CTRL_PS_LSB];
         swen_q <= CTRL_RESET[CTRL_SWEN_BIT];
      end else if (wr_ctrl) begin
         period_q <= wr_period;
         swen_q <= wdata_in[CTRL_SWEN_BIT];
      end
   end

   // option, configuration and mask are plain storage
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         option_q <= OPTION_RESET;
         config_q <= CONFIG_RESET;
         mask_q <= STATUS_RESET;
      end else if (wr_in) begin
         if (addr_in == REG_OPTION) begin
            option_q <= wdata_in;
         end
         if (addr_in == REG_CONFIG) begin
            config_q <= wdata_in;
         end
         if (addr_in == REG_MASK) begin
            mask_q <= wdata_in[STATUS_W-1:0];
         end
      end
   end

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         status_q <= STATUS_RESET;
      end else begin
         for (int i = 0; i < STATUS_W; i++) begin
            if (wr_in && addr_in == REG_STATUS && wdata_in[i]) begin
               status_q[i] <= 1'b0;
            end
         end
         if (timeout_evt) begin
            status_q[ST_TIMEOUT_BIT] <= 1'b1;
         end
         if (osc_fail_in) begin
            status_q[ST_OSCFAIL_BIT] <= 1'b1;
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads as zero
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !rd_in) begin
         rdata_out <= 8'h00;
      end else begin
         case (addr_in)
            REG_CTRL: rdata_out <= {3'h0, period_q, swen_q};
            REG_OPTION: rdata_out <= option_q;
            REG_CONFIG: rdata_out <= config_q;
            REG_STATUS: rdata_out <= {{(8-STATUS_W){1'b0}}, status_q};
            REG_MASK: rdata_out <= {{(8-STATUS_W){1'b0}}, mask_q};
            default: rdata_out <= 8'h00;
         endcase
      end
   end

   // outputs registered; the stable flag tracks the oscillator only
   // stable flag ignores watchdog
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         slow_osc_stable_out <= 1'b0;
         wdt_running_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         slow_osc_stable_out <= slow_osc_ready_in;
         wdt_running_out <= wdt_on;
         irq_out <= |(status_q & mask_q);
      end
   end

   // ********************************
   // assertions
   // ********************************
   a_tick_only_advance:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         (presc_q != $past(presc_q)) && (presc_q != '0) |-> $past(slow_tick))
      else $error("prescaler moved without a slow tick");
   a_div_at_term:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         div_evt |=> presc_q == '0)
      else $error("prescaler did not wrap at terminal count");
   a_term_from_code:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         period_q == 4'h0 |-> presc_term == 16'h001F)
      else $error("code zero is not a 1:32 division");
   a_period_reset:
      assert property (@(posedge sys_clk_in)
         reset_in |=> period_q == PERIOD_RESET && presc_term == 16'h01FF)
      else $error("reset period is not 1:512");
   a_ost_hold:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         ost_busy_in |=> presc_q == '0 && post_q == '0)
      else $error("counters ran during start-up count");
   a_fuse_force:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         config_q[CFG_FUSE_BIT] |=> wdt_running_out)
      else $error("fuse did not force the watchdog on");
   a_sw_off:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         !config_q[CFG_FUSE_BIT] && !swen_q |=> presc_q == '0 && !timeout_reset_out)
      else $error("disabled watchdog kept counting");
   a_swen_reset:
      assert property (@(posedge sys_clk_in)
         reset_in |=> !swen_q ##1 (!wdt_running_out || $past(config_q[CFG_FUSE_BIT])))
      else $error("software enable not cleared by reset");
   a_clear_sources:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         clear_wdt_in || osc_fail_in |=> presc_q == '0 && post_q == '0)
      else $error("clear source did not clear counters");
   a_xtal_hold:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         sleep_exit_in && xtal_mode_in && !ost_done_in ##1 !ost_done_in |=> presc_q == '0)
      else $error("count resumed before start-up ended");
   a_shared_path:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         timeout_evt && option_q[OPT_PSA_BIT] |-> post_q == post_term)
      else $error("timeout before shared prescaler terminal");
   a_stable_flag:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         !slow_osc_ready_in ##1 !slow_osc_ready_in |-> !slow_osc_stable_out)
      else $error("stable flag set by watchdog use");
   a_sleep_clear:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         sleep_enter_in |=> presc_q == '0 && pstate_q == PS_SLEEP)
      else $error("sleep entry did not clear counter");
   a_wake_clear:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         sleep_exit_in |=> presc_q == '0 && pstate_q == PS_RUN)
      else $error("wake did not clear counter");
   a_timeout_kind:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         timeout_evt |=> (timeout_wake_out ^ timeout_reset_out)
            && (timeout_wake_out == ($past(pstate_q) == PS_SLEEP)))
      else $error("timeout request of wrong kind");
   a_reserved_sat:
      assert property (@(posedge sys_clk_in) disable iff (reset_in)
         wr_ctrl && wdata_in[CTRL_PS_MSB:CTRL_PS_LSB] > PERIOD_MAX |=> period_q == PERIOD_MAX)
      else $error("reserved period code not saturated");
endmodule : watchdog_timer_unit

/* File: verif/testbench.sv */
// self-checking bench for the watchdog timer unit
// assumes wdt_pkg; the bench makes a fast slow-oscillator (one tick per 4 cycles)
`timescale 1ns/1ps
module testbench;
   import wdt_pkg::*;
   // ********************************
   // stimulus and observation
   // ********************************
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [ADDR_W-1:0] addr_in = '0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic slow_osc_in = 1'b0;
   logic slow_osc_ready_in = 1'b0;
   logic clear_wdt_in = 1'b0;
   logic osc_fail_in = 1'b0;
   logic ost_busy_in = 1'b0;
   logic ost_done_in = 1'b0;
   logic xtal_mode_in = 1'b0;
   logic sleep_enter_in = 1'b0;
   logic sleep_exit_in = 1'b0;
   logic [7:0] rdata_out;
   logic timeout_reset_out;
   logic timeout_wake_out;
   logic wdt_running_out;
   logic slow_osc_stable_out;
   logic irq_out;
   logic [1:0] div_q = 2'h0;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;

   watchdog_timer_unit watchdog_timer_unit_i (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .slow_osc_in(slow_osc_in), .slow_osc_ready_in(slow_osc_ready_in),
      .clear_wdt_in(clear_wdt_in), .osc_fail_in(osc_fail_in), .ost_busy_in(ost_busy_in),
      .ost_done_in(ost_done_in), .xtal_mode_in(xtal_mode_in),
      .sleep_enter_in(sleep_enter_in), .sleep_exit_in(sleep_exit_in),
      .timeout_reset_out(timeout_reset_out), .timeout_wake_out(timeout_wake_out),
      .wdt_running_out(wdt_running_out), .slow_osc_stable_out(slow_osc_stable_out),
      .irq_out(irq_out)
   );

   // ********************************
   // clocks and hang guard
   // ********************************
   always #10 sys_clk_in = ~sys_clk_in;

   // slow oscillator far faster than real, so a 1:32 period takes 128 cycles
   always @(posedge sys_clk_in) begin
      div_q <= div_q + 2'h1;
      slow_osc_in <= div_q[1];
   end

   // runs need about 3100 cycles; a hang is cut well after that
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         tally_and_finish();
      end
   end

   // ********************************
   // compare and bus tasks
   // ********************************
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : check8

   task automatic check1(input logic got, input logic exp);
      check8({7'h00, got}, {7'h00, exp});
   endtask : check1

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask : reg_wr

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      #1;
      check8(rdata_out, exp);
   endtask : rd_chk

   task automatic settle();
      repeat (2) @(posedge sys_clk_in);
      #1;
   endtask : settle

   // one-cycle core event: 0 clear, 1 osc fail, 2 sleep, 3 wake, 4 start-up done
   task automatic evt(input int k);
      @(posedge sys_clk_in);
      clear_wdt_in <= (k == 0);
      osc_fail_in <= (k == 1);
      sleep_enter_in <= (k == 2);
      sleep_exit_in <= (k == 3);
      ost_done_in <= (k == 4);
      @(posedge sys_clk_in);
      {clear_wdt_in, osc_fail_in, sleep_enter_in, sleep_exit_in, ost_done_in} <= 5'h00;
   endtask : evt

   // watch n cycles; kind 0 no timeout, 1 reset pulse, 2 wake pulse, first not before lo
   task automatic watch(input int n, input int lo, input int kind);
      int first;
      int got_kind;
      first = 0;
      got_kind = 0;
      for (int i = 1; i <= n; i++) begin
         @(posedge sys_clk_in);
         #1;
         // an unknown output counts as a third kind so it never passes as quiet
         if (first == 0 && (timeout_reset_out !== 1'b0 || timeout_wake_out !== 1'b0)) begin
            first = i;
            got_kind = (timeout_wake_out === 1'b1) ? 2 : ((timeout_reset_out === 1'b1) ? 1 : 3);
         end
      end
      check8(8'(got_kind), 8'(kind));
      if (kind != 0) check1(first >= lo, 1'b1);
   endtask : watch

   // ********************************
   // scenarios
   // ********************************
   task automatic t_reset_values();
      check1(irq_out, 1'b0);
      check1(wdt_running_out, 1'b0);
      rd_chk(REG_CTRL, CTRL_RESET);
      rd_chk(REG_OPTION, OPTION_RESET);
      rd_chk(REG_CONFIG, 8'h00);
      rd_chk(REG_STATUS, 8'h00);
      rd_chk(REG_MASK, 8'h00);
      reg_wr(3'h5, 8'hFF);
      rd_chk(3'h5, 8'h00);
   endtask : t_reset_values

   // every period code, reserved ones saturated, upper bits unimplemented
   task automatic t_period_codes();
      for (int c = 0; c < 16; c++) begin
         reg_wr(REG_CTRL, {3'h7, 4'(c), 1'b0});
         rd_chk(REG_CTRL, {3'h0, (c > 11) ? PERIOD_MAX : 4'(c), 1'b0});
      end
      reg_wr(REG_CTRL, 8'h1F);
      rd_chk(REG_CTRL, 8'h17);
      reg_wr(REG_CTRL, 8'h00);
      reg_wr(REG_OPTION, 8'h00);
      rd_chk(REG_OPTION, 8'h00);
   endtask : t_period_codes

   task automatic t_soft_enable();
      watch(300, 0, 0);
      reg_wr(REG_CTRL, 8'h01);
      settle();
      check1(wdt_running_out, 1'b1);
      check1(slow_osc_stable_out, 1'b0);
      evt(0);
      watch(140, 118, 1);
      reg_wr(REG_CTRL, 8'h00);
   endtask : t_soft_enable

   task automatic t_irq();
      rd_chk(REG_STATUS, 8'h01);
      check1(irq_out, 1'b0);
      reg_wr(REG_MASK, 8'h01);
      settle();
      check1(irq_out, 1'b1);
      reg_wr(REG_STATUS, 8'h01);
      settle();
      check1(irq_out, 1'b0);
      rd_chk(REG_STATUS, 8'h00);
   endtask : t_irq

   task automatic t_fuse();
      reg_wr(REG_CONFIG, 8'h08);
      settle();
      check1(wdt_running_out, 1'b1);
      evt(0);
      watch(140, 118, 1);
      reg_wr(REG_CONFIG, 8'h00);
      settle();
      check1(wdt_running_out, 1'b0);
      reg_wr(REG_STATUS, 8'h03);
   endtask : t_fuse

   task automatic t_clears();
      reg_wr(REG_CTRL, 8'h01);
      for (int k = 0; k < 8; k++) begin
         watch(100, 0, 0);
         evt(k / 4);
      end
      rd_chk(REG_STATUS, 8'h02);
      @(posedge sys_clk_in);
      ost_busy_in <= 1'b1;
      watch(300, 0, 0);
      @(posedge sys_clk_in);
      ost_busy_in <= 1'b0;
      watch(140, 118, 1);
   endtask : t_clears

   // level inputs change only at a rising edge
   task automatic t_sleep();
      @(posedge sys_clk_in);
      xtal_mode_in <= 1'b1;
      evt(0);
      evt(2);
      watch(140, 118, 2);
      evt(3);
      watch(300, 0, 0);
      evt(4);
      watch(140, 118, 1);
      @(posedge sys_clk_in);
      xtal_mode_in <= 1'b0;
      evt(2);
      watch(100, 0, 0);
      evt(3);
      watch(140, 118, 1);
   endtask : t_sleep

   task automatic t_shared();
      reg_wr(REG_OPTION, 8'h09);
      evt(0);
      watch(280, 245, 1);
      @(posedge sys_clk_in);
      slow_osc_ready_in <= 1'b1;
      settle();
      check1(slow_osc_stable_out, 1'b1);
   endtask : t_shared

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (16) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      settle();
      t_reset_values();
      t_period_codes();
      t_soft_enable();
      t_irq();
      t_fuse();
      t_clears();
      t_sleep();
      t_shared();
      tally_and_finish();
   end
endmodule : testbench
